// ### design/wlbc_burst_mod.sv
// Burst pattern duty modulator for the LED switch
`timescale 1ns/1ps
`default_nettype none
module wlbc_burst_mod #(
	parameter int unsigned DUTY_W = wlbc_pkg::DUTY_W,
	parameter int unsigned DIV_W  = wlbc_pkg::DIV_W
) (
	input  wire logic              core_clk,
	input  wire logic              rst_n,
	input  wire logic              enable,
	input  wire logic [DUTY_W-1:0] duty,
	input  wire logic              high_rate,
	output var  logic              led_on
);

	logic [DIV_W-1:0]  div_q;
	logic              phase_q;
	logic [DUTY_W-1:0] pulse_q;
	logic [DUTY_W-1:0] duty_lat_q;
	logic              rate_lat_q;
	logic [DIV_W-1:0]  half_lim;
	logic              tick;
	logic              period_end;
	logic [DUTY_W-1:0] pulse_rev;
	logic [DUTY_W-2:0] mag;
	logic [DUTY_W-1:0] dev_cnt;
	logic              above_half;
	logic              special;
	logic              level;

	// ==========================================================
	// Half-pulse divider
	assign half_lim   = high_rate_sel(rate_lat_q);
	assign tick       = (div_q == half_lim - DIV_W'(1));
	assign period_end = tick & phase_q & (pulse_q == '1);

	function automatic logic [DIV_W-1:0] high_rate_sel(input logic hi);
		return hi ? DIV_W'(wlbc_pkg::HALF_CYC_HI) : DIV_W'(wlbc_pkg::HALF_CYC_LO);
	endfunction : high_rate_sel

	// ==========================================================
	// Pattern: bit-reversed index spreads forced pulses evenly
	always_comb begin
		for (int i = 0; i < DUTY_W; i++) begin
			pulse_rev[i] = pulse_q[DUTY_W-1-i];
		end
	end

	// Two forced pulses per step keep the average exact
	assign above_half = duty_lat_q[DUTY_W-1];
	assign mag = above_half ? duty_lat_q[DUTY_W-2:0]
	                        : (DUTY_W-1)'(~duty_lat_q[DUTY_W-2:0] + 1'b1);
	assign dev_cnt = {mag, 1'b0};
	// At most 254 forced pulses, so full on never happens
	assign special = (pulse_rev < dev_cnt);
	assign level   = special ? above_half : ~phase_q;

	// ==========================================================
	// Counters; restart cleanly whenever disabled
	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			div_q   <= '0;
			phase_q <= 1'b0;
			pulse_q <= '0;
		end else if (!enable) begin
			div_q   <= '0;
			phase_q <= 1'b0;
			pulse_q <= '0;
		end else if (tick) begin
			div_q   <= '0;
			phase_q <= ~phase_q;
			if (phase_q) begin
				pulse_q <= pulse_q + DUTY_W'(1);
			end
		end else begin
			div_q <= div_q + DIV_W'(1);
		end
	end

	// Settings change only at period edges or while disabled, so a pattern never tears
	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			duty_lat_q <= '0;
			rate_lat_q <= 1'b0;
		end else if (!enable || period_end) begin
			duty_lat_q <= duty;
			rate_lat_q <= high_rate;
		end
	end

	// Registered gate level
	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			led_on <= 1'b0;
		end else begin
			led_on <= enable & level;
		end
	end

endmodule : wlbc_burst_mod
`default_nettype wire

// ### design/wlbc_pkg.sv
// Constants, types and timing for the white LED boost control block
// What this block does
// - Burst pattern averages to programmed duty
// - Half duty gives every pulse half shape
// - Pulses forced full on or off otherwise
// - Rate bit one selects higher repetition rate
// - Period holds 256 pulses, one step each
// - Zero duty keeps converter off, no switching
// - Nonzero duty enables, soft start then regulation
// - Duty spans one step to just below full
// - Switch on when feedback low, LED on
// - Switch off on peak trip or timeout
// - LED off forces power switch off
// - Soft start limit in three rising levels
// - Each lower level lasts 256 switch cycles
// - Shutdown holds the LED switch open
// - LED gate driven by duty modulator
// - Overvoltage turns power switch off meanwhile
// - Lockout or overtemperature forces off mode
`default_nettype none
package wlbc_pkg;

	// ==========================================================
	// Clock and modulator timing
	localparam int unsigned CLK_HZ            = 100_000_000;
	localparam int unsigned CLK_PERIOD_NS     = 10;
	localparam int unsigned REP_HZ_HI         = 183;
	localparam int unsigned REP_HZ_LO         = 122;
	localparam int unsigned PULSES_PER_PERIOD = 256;
	localparam int unsigned DUTY_W            = 8;
	localparam int unsigned DIV_W             = 12;
	// Half of one pulse, rounded down
	localparam int unsigned HALF_CYC_HI = CLK_HZ / (REP_HZ_HI * PULSES_PER_PERIOD * 2);
	localparam int unsigned HALF_CYC_LO = CLK_HZ / (REP_HZ_LO * PULSES_PER_PERIOD * 2);

	// ==========================================================
	// Reset values and switch timing
	localparam logic [7:0] DUTY_RST     = 8'h00;
	localparam int unsigned MAX_ON_NS   = 6000;
	// Longest time, so rounded down
	localparam int unsigned MAX_ON_CYC  = MAX_ON_NS / CLK_PERIOD_NS;
	localparam int unsigned ON_CNT_W    = 10;
	localparam int unsigned SS_CYCLES   = 256;
	localparam int unsigned SS_CNT_W    = 8;

	// ==========================================================
	// Current limit codes toward the power stage
	localparam logic [1:0] ILIM_125 = 2'h0;
	localparam logic [1:0] ILIM_250 = 2'h1;
	localparam logic [1:0] ILIM_500 = 2'h2;

	// ==========================================================
	// Types
	typedef enum {SW_OFF, SW_WAIT, SW_ON} wlbc_sw_state_t;
	typedef enum {SS_LOW, SS_MID, SS_FULL} wlbc_ss_stage_t;

	typedef struct packed {
		logic fb_below_ref;
		logic peak_trip;
		logic ovp_trip;
		logic uvlo;
		logic thermal_shutdown;
	} wlbc_cmp_t;

	localparam int unsigned CMP_W   = 5;
	localparam logic [4:0]  CMP_RST = 5'h00;

	typedef struct packed {
		logic       converter_on;
		logic       soft_start;
		logic [1:0] ilim_code;
	} wlbc_status_t;

endpackage : wlbc_pkg
`default_nettype wire

// ### design/wlbc_sync.sv
// Three-stage synchroniser with agreement filter for comparator inputs
`timescale 1ns/1ps
`default_nettype none
module wlbc_sync #(
	parameter int unsigned W = 1
) (
	input  wire logic         core_clk,
	input  wire logic         rst_n,
	input  wire logic [W-1:0] d,
	output var  logic [W-1:0] q
);

	// ==========================================================
	// Stages
	logic [W-1:0] s1_q;
	logic [W-1:0] s2_q;
	logic [W-1:0] s3_q;

	// Chain; only the second stage reads the first
	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			s1_q <= '0;
			s2_q <= '0;
			s3_q <= '0;
		end else begin
			s1_q <= d;
			s2_q <= s1_q;
			s3_q <= s2_q;
		end
	end

	// A bit changes only where stages two and three agree
	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			q <= '0;
		end else begin
			q <= (s2_q & s3_q) | (q & (s2_q ^ s3_q));
		end
	end

endmodule : wlbc_sync
`default_nettype wire

// ### design/wlbc_top.sv
// Top of the white LED boost control: duty register, modulator and switch control
`timescale 1ns/1ps
`default_nettype none
module wlbc_top (
	input  wire logic                  core_clk,
	input  wire logic                  rst_n,
	// Host side, same clock
	input  wire logic                  duty_wr_en,
	input  wire logic [7:0]            duty_wr_data,
	input  wire logic                  led_switch_rate_select,
	// Analogue comparators, asynchronous
	input  wire wlbc_pkg::wlbc_cmp_t   cmp_raw,
	// Power stage side
	output var  logic                  power_switch_gate,
	output var  logic                  backlight_pulse_output,
	output var  logic [1:0]            ilim_code,
	// Readback and status
	output var  logic [7:0]            led_duty_setting,
	output var  wlbc_pkg::wlbc_status_t status
);

	// ==========================================================
	// Operation overview
	//
	// Off mode: duty zero, lockout or overtemperature. Both gates stay low,
	// the modulator is held at the start of its pattern and soft start
	// drops back to the lowest limit.
	//
	// Enable: a nonzero duty write raises the live enable at once. The
	// modulator follows one cycle later so that it latches the new duty
	// before its first pulse, and the LED gate follows the modulator.
	//
	// Switching: the power switch only turns on from the wait state, with
	// the LED gate high, feedback low and no trip or overvoltage seen. It
	// turns off on a peak trip, the on-time limit, the LED gate falling or
	// overvoltage, and then waits at least one cycle before a new turn-on.
	// A falling LED gate stops the power switch one edge later.
	//
	// Latency: comparator changes take four cycles to reach the logic, so
	// the gate can outlast a peak trip by about five cycles. The power
	// stage must tolerate that overshoot.
	//
	// Soft start: a switching cycle is counted when it ends, so each lower
	// limit governs 256 whole cycles before the next one applies.
	//
	// Rate select is a same-clock level and is latched with the duty, so
	// a change takes effect at the next period edge or the next enable.
	//
	// Status: a registered snapshot for the host, one cycle behind the
	// live enable and the limit code.

	// ==========================================================
	// Declarations

	// Synchronised comparator view
	wlbc_pkg::wlbc_cmp_t cmp;

	// Duty register and enable
	logic [7:0] duty_q;
	logic       conv_en;
	logic       conv_q;
	logic       fault;

	// Modulator output before final gating
	logic       burst_on;

	// LED switch gate register
	logic       led_gate_q;

	// Power switch control
	wlbc_pkg::wlbc_sw_state_t sw_state_q;
	wlbc_pkg::wlbc_sw_state_t sw_state_d;
	logic [wlbc_pkg::ON_CNT_W-1:0] on_cnt_q;
	logic       on_timeout;
	logic       sw_start;
	logic       sw_stop;
	logic       sw_gate_q;

	// Soft start
	wlbc_pkg::wlbc_ss_stage_t ss_stage_q;
	logic [wlbc_pkg::SS_CNT_W-1:0] ss_cnt_q;
	logic       ss_cnt_last;
	logic       sw_cycle_end;
	logic [1:0] ilim_q;

	// Status register
	wlbc_pkg::wlbc_status_t status_q;

	// ==========================================================
	// Comparator synchronisers

	// Comparators are analogue and free running, so all pass three stages
	wlbc_sync #(
		.W (wlbc_pkg::CMP_W)
	) u_cmp_sync (
		.core_clk (core_clk),
		.rst_n    (rst_n),
		.d        (cmp_raw),
		.q        (cmp)
	);

	// ==========================================================
	// Duty register

	// Reset leaves the converter off
	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			duty_q <= wlbc_pkg::DUTY_RST;
		end else if (duty_wr_en) begin
			duty_q <= duty_wr_data;
		end
	end

	// ==========================================================
	// Converter enable

	// Lockout and overtemperature override any duty setting
	assign fault = cmp.uvlo | cmp.thermal_shutdown;

	// Any nonzero duty enables the converter when no lockout or overtemperature is seen
	assign conv_en = (duty_q != 8'h00) & ~fault;

	// Delayed enable lets the modulator latch the new duty first
	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			conv_q <= 1'b0;
		end else begin
			conv_q <= conv_en;
		end
	end

	// ==========================================================
	// Duty modulator

	// One set bit selects the faster repetition rate
	wlbc_burst_mod #(
		.DUTY_W (wlbc_pkg::DUTY_W),
		.DIV_W  (wlbc_pkg::DIV_W)
	) u_burst (
		.core_clk  (core_clk),
		.rst_n     (rst_n),
		.enable    (conv_q),
		.duty      (duty_q),
		.high_rate (led_switch_rate_select),
		.led_on    (burst_on)
	);

	// ==========================================================
	// LED switch gate

	// Gated by the live enable, so off mode opens it at once
	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			led_gate_q <= 1'b0;
		end else begin
			led_gate_q <= conv_en & burst_on;
		end
	end

	// ==========================================================
	// Power switch conditions

	// Start needs feedback low, LED on, no trip and no overvoltage
	assign sw_start = cmp.fb_below_ref & led_gate_q
	                & ~cmp.peak_trip & ~cmp.ovp_trip;

	// Maximum on-time measured from the first on cycle
	assign on_timeout = (on_cnt_q == wlbc_pkg::ON_CNT_W'(wlbc_pkg::MAX_ON_CYC - 1));

	// Whichever stop cause comes first ends the on phase
	assign sw_stop = cmp.peak_trip | on_timeout
	               | ~led_gate_q
	               | cmp.ovp_trip;

	// ==========================================================
	// Power switch state machine

	always_comb begin
		sw_state_d = sw_state_q;
		unique case (sw_state_q)
			wlbc_pkg::SW_OFF: begin
				if (conv_en) begin
					sw_state_d = wlbc_pkg::SW_WAIT;
				end
			end
			wlbc_pkg::SW_WAIT: begin
				if (!conv_en) begin
					sw_state_d = wlbc_pkg::SW_OFF;
				end else if (sw_start) begin
					sw_state_d = wlbc_pkg::SW_ON;
				end
			end
			wlbc_pkg::SW_ON: begin
				if (!conv_en) begin
					sw_state_d = wlbc_pkg::SW_OFF;
				end else if (sw_stop) begin
					sw_state_d = wlbc_pkg::SW_WAIT;
				end
			end
		endcase
	end

	// State register
	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			sw_state_q <= wlbc_pkg::SW_OFF;
		end else begin
			sw_state_q <= sw_state_d;
		end
	end

	// Gate follows the next state so it matches the state register
	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			sw_gate_q <= 1'b0;
		end else begin
			sw_gate_q <= (sw_state_d == wlbc_pkg::SW_ON);
		end
	end

	// On-time counter, cleared outside the on phase
	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			on_cnt_q <= '0;
		end else if (sw_state_q == wlbc_pkg::SW_ON && sw_state_d == wlbc_pkg::SW_ON) begin
			on_cnt_q <= on_cnt_q + wlbc_pkg::ON_CNT_W'(1);
		end else begin
			on_cnt_q <= '0;
		end
	end

	// ==========================================================
	// Soft start

	// Counted at its end, so the last cycle of a level runs at that level
	assign sw_cycle_end = (sw_state_q == wlbc_pkg::SW_ON)
	                    & (sw_state_d == wlbc_pkg::SW_WAIT);
	assign ss_cnt_last = (ss_cnt_q == wlbc_pkg::SS_CNT_W'(wlbc_pkg::SS_CYCLES - 1));

	// Off mode returns to the lowest level, so every enable restarts it
	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			ss_stage_q <= wlbc_pkg::SS_LOW;
			ss_cnt_q   <= '0;
		end else if (!conv_en) begin
			ss_stage_q <= wlbc_pkg::SS_LOW;
			ss_cnt_q   <= '0;
		end else if (sw_cycle_end && ss_stage_q != wlbc_pkg::SS_FULL) begin
			if (ss_cnt_last) begin
				ss_cnt_q <= '0;
				if (ss_stage_q == wlbc_pkg::SS_LOW) begin
					ss_stage_q <= wlbc_pkg::SS_MID;
				end else begin
					ss_stage_q <= wlbc_pkg::SS_FULL;
				end
			end else begin
				ss_cnt_q <= ss_cnt_q + wlbc_pkg::SS_CNT_W'(1);
			end
		end
	end

	// Limit code toward the peak-current comparator
	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			ilim_q <= wlbc_pkg::ILIM_125;
		end else begin
			unique case (ss_stage_q)
				wlbc_pkg::SS_LOW:  ilim_q <= wlbc_pkg::ILIM_125;
				wlbc_pkg::SS_MID:  ilim_q <= wlbc_pkg::ILIM_250;
				wlbc_pkg::SS_FULL: ilim_q <= wlbc_pkg::ILIM_500;
			endcase
		end
	end

	// ==========================================================
	// Status

	// Snapshot of enable, soft start phase and limit
	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			status_q <= '0;
		end else begin
			status_q.converter_on <= conv_en;
			status_q.soft_start   <= conv_en & (ss_stage_q != wlbc_pkg::SS_FULL);
			status_q.ilim_code    <= ilim_q;
		end
	end

	// ==========================================================
	// Outputs, all straight from registers

	assign power_switch_gate      = sw_gate_q;
	assign backlight_pulse_output = led_gate_q;
	assign ilim_code              = ilim_q;
	assign led_duty_setting       = duty_q;
	assign status                 = status_q;

endmodule : wlbc_top
`default_nettype wire

// ### sim/tb_white_led_boost_control.sv
// Self-checking testbench of the white LED boost control
`timescale 1ns/1ps
`default_nettype none
`define CHK(nm, ex, gt) begin checks_done++; if ((gt) !== (ex)) begin error_cnt++; \
	$display("Error %s expected %0h seen %0h", nm, ex, gt); end end
module tb_white_led_boost_control;
	logic                   core_clk = 1'b0;
	logic                   rst_n = 1'b0;
	logic                   duty_wr_en = 1'b0;
	logic [7:0]             duty_wr_data = 8'h00;
	logic                   led_switch_rate_select = 1'b1;
	logic                   slow = 1'b0;
	logic                   ovp = 1'b0;
	logic [1:0]             halt = 2'h0;
	wlbc_pkg::wlbc_cmp_t    cmp_raw;
	logic                   power_switch_gate;
	logic                   backlight_pulse_output;
	logic [1:0]             ilim_code;
	logic [7:0]             led_duty_setting;
	wlbc_pkg::wlbc_status_t status;
	int                     error_cnt = 0;
	int                     checks_done = 0;
	int                     rises = 0;
	int                     n;
	// ==========
	// Clock, instances, gate turn-on counter
	always #5 core_clk = ~core_clk;
	always @(posedge power_switch_gate) rises++;
	wlbc_top DUT (.core_clk(core_clk), .rst_n(rst_n), .duty_wr_en(duty_wr_en),
		.duty_wr_data(duty_wr_data), .led_switch_rate_select(led_switch_rate_select),
		.cmp_raw(cmp_raw), .power_switch_gate(power_switch_gate),
		.backlight_pulse_output(backlight_pulse_output), .ilim_code(ilim_code),
		.led_duty_setting(led_duty_setting), .status(status));
	wlbc_stage_model u_stage (.core_clk(core_clk), .rst_n(rst_n),
		.power_switch_gate(power_switch_gate), .slow(slow), .ovp(ovp), .uvlo(halt[1]),
		.thermal(halt[0]), .cmp(cmp_raw));
	// ==========
	// Shared tasks
	task automatic tally_and_finish;
		if (error_cnt == 0 && checks_done > 0)
			$display("NO MISMATCHES");
		else
			$display("MISMATCHES SEEN");
		$finish;
	endtask : tally_and_finish
	function automatic logic pick(input int w);
		case (w)
			0: return backlight_pulse_output;
			1: return power_switch_gate;
			2: return ilim_code == 2'h1;
			default: return ilim_code == 2'h2;
		endcase
	endfunction : pick
	// Bounded wait; a hang counts as a mismatch
	task automatic wait_for(input int w, input int lim);
		int k = 0;
		while (pick(w) !== 1'b1) begin
			@(negedge core_clk);
			k++;
			if (k > lim) begin
				error_cnt++;
				$display("Error wait %0d expected 1 seen 0", w);
				tally_and_finish();
			end
		end
	endtask : wait_for
	// Cycles that a level lasts, capped at lim
	task automatic run_len(input int w, input logic lvl, input int lim);
		n = 0;
		while (pick(w) === lvl && n < lim) begin
			n++;
			@(negedge core_clk);
		end
	endtask : run_len
	task automatic wr(input logic [7:0] v);
		@(posedge core_clk);
		duty_wr_en   <= 1'b1;
		duty_wr_data <= v;
		@(posedge core_clk);
		duty_wr_en <= 1'b0;
		@(negedge core_clk);
	endtask : wr
	// ==========
	// Scenarios
	task automatic t_reset;
		`CHK("duty", 8'h00, led_duty_setting)
		`CHK("led", 1'b0, backlight_pulse_output)
		`CHK("ilim", 2'h0, ilim_code)
		`CHK("gate", 1'b0, power_switch_gate)
	endtask : t_reset
	task automatic t_half;
		wr(8'h80);
		`CHK("duty", 8'h80, led_duty_setting)
		wait_for(0, 20);
		`CHK("conv on", 1'b1, status.converter_on)
		`CHK("soft", 1'b1, status.soft_start)
		run_len(0, 1'b1, 4000);
		`CHK("half on", int'(wlbc_pkg::HALF_CYC_HI), n)
		run_len(0, 1'b0, 4000);
		`CHK("half off", int'(wlbc_pkg::HALF_CYC_HI), n)
	endtask : t_half
	// Smallest step either side of half: two pulses forced each way
	task automatic t_shape;
		wr(8'h00);
		wr(8'h81);
		wait_for(0, 20);
		run_len(0, 1'b1, 8000);
		`CHK("forced on", int'(3 * wlbc_pkg::HALF_CYC_HI), n)
		wr(8'h00);
		wr(8'h7f);
		run_len(0, 1'b0, 2100);
		`CHK("forced off", 2100, n)
		wait_for(0, 200);
		run_len(0, 1'b1, 4000);
		`CHK("next half", int'(wlbc_pkg::HALF_CYC_HI), n)
	endtask : t_shape
	task automatic t_rate;
		wr(8'h00);
		@(posedge core_clk);
		led_switch_rate_select <= 1'b0;
		wr(8'h80);
		wait_for(0, 20);
		run_len(0, 1'b1, 4000);
		`CHK("low rate", int'(wlbc_pkg::HALF_CYC_LO), n)
		@(posedge core_clk);
		led_switch_rate_select <= 1'b1;
	endtask : t_rate
	task automatic t_timeout;
		wr(8'h00);
		@(posedge core_clk);
		slow <= 1'b1;
		wr(8'h80);
		wait_for(1, 100);
		run_len(1, 1'b1, 2000);
		`CHK("max on", int'(wlbc_pkg::MAX_ON_CYC), n)
		@(posedge core_clk);
		slow <= 1'b0;
	endtask : t_timeout
	task automatic t_soft;
		wr(8'h00);
		rises = 0;
		wr(8'hff);
		wait_for(2, 30000);
		`CHK("turn-ons mid", 256, rises)
		`CHK("soft", 1'b1, status.soft_start)
		wait_for(3, 30000);
		`CHK("turn-ons full", 512, rises)
		repeat (2) @(negedge core_clk);
		`CHK("soft end", 1'b0, status.soft_start)
		`CHK("status ilim", 2'h2, status.ilim_code)
		wr(8'h00);
		repeat (2) @(negedge core_clk);
		`CHK("led", 1'b0, backlight_pulse_output)
		`CHK("gate", 1'b0, power_switch_gate)
		`CHK("ilim", 2'h0, ilim_code)
		wr(8'hff);
		repeat (200) @(negedge core_clk);
		`CHK("restart", 2'h0, ilim_code)
	endtask : t_soft
	task automatic t_fault;
		@(posedge core_clk);
		ovp <= 1'b1;
		repeat (8) @(negedge core_clk);
		run_len(1, 1'b0, 300);
		`CHK("ovp off", 300, n)
		@(posedge core_clk);
		ovp <= 1'b0;
		wait_for(1, 300);
		for (int k = 0; k < 2; k++) begin
			@(posedge core_clk);
			halt <= 2'h1 << k;
			repeat (8) @(negedge core_clk);
			run_len(0, 1'b0, 300);
			`CHK("led held", 300, n)
			`CHK("gate held", 1'b0, power_switch_gate)
			@(posedge core_clk);
			halt <= 2'h0;
			wait_for(0, 300);
		end
	endtask : t_fault
	// ==========
	// Main sequence
	initial begin
		repeat (8) @(posedge core_clk);
		rst_n <= 1'b1;
		@(negedge core_clk);
		t_reset();
		t_half();
		t_shape();
		t_rate();
		t_timeout();
		t_soft();
		t_fault();
		tally_and_finish();
	end
endmodule : tb_white_led_boost_control
bind wlbc_top wlbc_assertions u_chk (.core_clk(core_clk), .rst_n(rst_n),
	.duty_wr_en(duty_wr_en), .duty_wr_data(duty_wr_data), .cmp_raw(cmp_raw),
	.power_switch_gate(power_switch_gate), .backlight_pulse_output(backlight_pulse_output),
	.ilim_code(ilim_code), .led_duty_setting(led_duty_setting));
`default_nettype wire

// ### sim/wlbc_assertions.sv
// Concurrent checks on the white LED boost control top ports
`timescale 1ns/1ps
`default_nettype none
module wlbc_assertions (
	input wire logic                core_clk,
	input wire logic                rst_n,
	input wire logic                duty_wr_en,
	input wire logic [7:0]          duty_wr_data,
	input wire wlbc_pkg::wlbc_cmp_t cmp_raw,
	input wire logic                power_switch_gate,
	input wire logic                backlight_pulse_output,
	input wire logic [1:0]          ilim_code,
	input wire logic [7:0]          led_duty_setting
);
	// ==========
	// Helper logic
	default clocking @(posedge core_clk); endclocking
	default disable iff (!rst_n);
	logic [9:0] on_cnt_q;
	// Length of the present on time, cleared when the gate drops
	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n)
			on_cnt_q <= 10'h000;
		else
			on_cnt_q <= power_switch_gate ? on_cnt_q + 10'h001 : 10'h000;
	end
	// ==========
	// Properties
	property p_wr; duty_wr_en |=> led_duty_setting == $past(duty_wr_data); endproperty
	a_wr: assert property (p_wr) else $error("duty readback wrong");
	property p_zero; led_duty_setting == 8'h00 |=> !backlight_pulse_output; endproperty
	a_zero: assert property (p_zero) else $error("led on with zero duty");
	property p_gate_led; $rose(power_switch_gate) |-> $past(backlight_pulse_output); endproperty
	a_gate_led: assert property (p_gate_led) else $error("gate rose with led off");
	property p_led_off; !backlight_pulse_output |=> !power_switch_gate; endproperty
	a_led_off: assert property (p_led_off) else $error("gate kept with led off");
	property p_max_on; on_cnt_q <= 10'h258; endproperty
	a_max_on: assert property (p_max_on) else $error("gate on too long");
	// Limit only climbs one step at a time or drops back to the lowest
	property p_ilim;
		ilim_code != $past(ilim_code) |->
			ilim_code == 2'h0 || (ilim_code == $past(ilim_code) + 2'h1 && ilim_code != 2'h3);
	endproperty
	a_ilim: assert property (p_ilim) else $error("limit step wrong");
	property p_ovp; cmp_raw.ovp_trip [*6] |=> !power_switch_gate; endproperty
	a_ovp: assert property (p_ovp) else $error("gate on in overvoltage");
	property p_peak; cmp_raw.peak_trip [*6] |=> !power_switch_gate; endproperty
	a_peak: assert property (p_peak) else $error("gate on past peak");
	property p_uvlo;
		cmp_raw.uvlo [*6] |=> !backlight_pulse_output && !power_switch_gate;
	endproperty
	a_uvlo: assert property (p_uvlo) else $error("switch on in lockout");
	property p_therm;
		cmp_raw.thermal_shutdown [*6] |=> !backlight_pulse_output && !power_switch_gate;
	endproperty
	a_therm: assert property (p_therm) else $error("switch on when hot");
endmodule : wlbc_assertions
`default_nettype wire

// ### sim/wlbc_stage_model.sv
// Behavioural boost power stage with its comparators
`timescale 1ns/1ps
`default_nettype none
module wlbc_stage_model #(
	parameter int unsigned PEAK_DLY = 16
) (
	input  wire logic                core_clk,
	input  wire logic                rst_n,
	input  wire logic                power_switch_gate,
	input  wire logic                slow,
	input  wire logic                ovp,
	input  wire logic                uvlo,
	input  wire logic                thermal,
	output var  wlbc_pkg::wlbc_cmp_t cmp
);
	logic [5:0] on_q;
	logic [3:0] hold_q;
	// Inductor ramp; a slow stage never reaches the peak, to force timeouts
	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			on_q   <= 6'h00;
			hold_q <= 4'h0;
		end else begin
			on_q <= power_switch_gate ? on_q + {5'h00, on_q != 6'h3f} : 6'h00;
			if (on_q >= 6'(PEAK_DLY) && !slow)
				hold_q <= 4'hc;
			else if (hold_q != 4'h0)
				hold_q <= hold_q - 4'h1;
		end
	end
	// Feedback sits low except while the inductor discharges
	assign cmp = {hold_q == 4'h0, hold_q != 4'h0, ovp, uvlo, thermal};
endmodule : wlbc_stage_model
`default_nettype wire
